// ---- design/asor_top.sv ----
// accelerometer sample output registers: flags, samples, burst pointer
//
// Operation
// - status register at 0x00, flag layout fixed
// - axis fresh sets on sample, clears on high read
// - unread sample replaced and overrun flagged
// - combined fresh clears after all high reads
// - combined overrun clears after all high reads
// - all flags clear after reset
// - ten bit sample split high and low
// - samples at 0x01..0x06, seven byte burst
// - fast read skips low bytes in bursts
// - low byte matches preceding high byte sample
// - samples taken only in measuring mode
// - ready source clears with combined fresh flag
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module asor_top
    import asor_pkg::*;
#(
    parameter int unsigned W = SMP_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // register port
    input  wire logic [7:0]   addr_i,
    input  wire logic [7:0]   wdata_i,
    input  wire logic         wr_i,
    input  wire logic         rd_i,
    input  wire logic         burst_i,     // read at auto-increment pointer
    output logic      [7:0]   rdata_o,
    output logic      [7:0]   next_addr_o, // auto-increment pointer
    // sample sources
    input  wire logic         x_new_i,
    input  wire logic [W-1:0] x_sample_i,
    input  wire logic         y_new_i,
    input  wire logic [W-1:0] y_sample_i,
    input  wire logic         z_new_i,
    input  wire logic [W-1:0] z_sample_i,
    // interrupt side
    output logic              sample_ready_irq_source_o,
    output logic              irq_o
);
    // top state
    typedef struct packed {
        logic [7:0]      ctrl;        // primary_control
        logic [7:0]      rdata;
        logic [7:0]      ptr;
        logic [AXES-1:0] mask;        // high bytes read since last clear
        logic            any_fresh;
        logic            any_ovr;
    } asor_top_s;

    asor_top_s s_q;  // registered state
    asor_top_s s_d;  // next state

    // step the burst pointer, wrapping after the z bytes
    function automatic logic [7:0] asor_step(input logic [7:0] a, input logic fast);
        logic [7:0] n;
        n = a + 8'h01;
        if (fast && (a == ADDR_X_HI || a == ADDR_Y_HI)) begin
            n = a + 8'h02;
        end else if (fast && a == ADDR_Z_HI) begin
            n = ADDR_FLAGS;
        end else if (a == ADDR_Z_LO) begin
            n = ADDR_FLAGS;
        end
        return n;
    endfunction

    // one strobe aimed at one register address
    function automatic logic asor_hit(input logic stb, input logic [7:0] a,
                                      input logic [7:0] target);
        return stb && a == target;
    endfunction

    logic [AXES-1:0]      new_raw;   // sample strobes as arrived
    logic [AXES-1:0]      new_v;     // strobes accepted while measuring
    logic [AXES-1:0]      msb_rd;    // high byte read per axis
    logic [AXES-1:0]      fresh_v;   // axis fresh flags
    logic [AXES-1:0]      ovr_v;     // axis overrun flags
    logic [AXES-1:0][W-1:0] smp_in;  // sample inputs per axis
    logic [AXES-1:0][7:0] msb_v;     // high bytes per axis
    logic [AXES-1:0][7:0] lsb_v;     // held low bytes per axis
    logic [7:0]           rd_addr;   // address of this read
    logic [7:0]           flags;     // sample_flags view
    logic                 act_clr;   // entry into measuring mode
    logic                 ctrl_wr;   // write to primary_control
    logic [IRQ_W-1:0]     irq_ev;    // interrupt events
    logic [IRQ_W-1:0]     irq_st;    // interrupt status
    logic [IRQ_W-1:0]     irq_en;    // interrupt enable

    assign new_raw = {z_new_i, y_new_i, x_new_i};
    assign smp_in  = {z_sample_i, y_sample_i, x_sample_i};
    assign new_v   = new_raw & {AXES{s_q.ctrl[CTRL_ACTIVE_BIT]}};
    assign rd_addr = burst_i ? s_q.ptr : addr_i;
    assign ctrl_wr = asor_hit(wr_i, addr_i, ADDR_CTRL);
    assign act_clr = ctrl_wr && wdata_i[CTRL_ACTIVE_BIT] && !s_q.ctrl[CTRL_ACTIVE_BIT];
    // high byte strobes per axis
    assign msb_rd  = {asor_hit(rd_i, rd_addr, ADDR_Z_HI),
                      asor_hit(rd_i, rd_addr, ADDR_Y_HI),
                      asor_hit(rd_i, rd_addr, ADDR_X_HI)};
    // status byte: overruns high, fresh flags low
    assign flags   = {s_q.any_ovr, ovr_v, s_q.any_fresh, fresh_v};
    assign irq_ev[IRQ_READY_BIT] = |new_v;
    assign irq_ev[IRQ_OVR_BIT]   = |(new_v & fresh_v & ~msb_rd);

    // one store per axis
    for (genvar i = 0; i < AXES; i++) begin : g_axis
        asor_axis #(.W(W)) u_axis (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .new_i    (new_v[i]),
            .sample_i (smp_in[i]),
            .clr_i    (act_clr),
            .msb_rd_i (msb_rd[i]),
            .fresh_o  (fresh_v[i]),
            .ovr_o    (ovr_v[i]),
            .msb_o    (msb_v[i]),
            .lsb_o    (lsb_v[i])
        );
    end

    // interrupt status, clear and enable
    asor_irq u_irq (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .event_i  (irq_ev),
        .clr_wr_i (asor_hit(wr_i, addr_i, ADDR_IRQ_CLR)),
        .en_wr_i  (asor_hit(wr_i, addr_i, ADDR_IRQ_EN)),
        .wdata_i  (wdata_i[IRQ_W-1:0]),
        .status_o (irq_st),
        .enable_o (irq_en),
        .irq_o    (irq_o)
    );

    // next state: control, read mux, pointer and combined flags
    always_comb begin
        logic [AXES-1:0] seen;
        seen = s_q.mask | msb_rd;
        s_d = s_q;
        s_d.rdata = BYTE_ZERO;                       // data only in the answer cycle
        if (ctrl_wr) begin
            s_d.ctrl = wdata_i;
        end
        if (rd_i) begin
            s_d.ptr = asor_step(rd_addr, s_q.ctrl[CTRL_FAST_BIT]);
            case (rd_addr)
                ADDR_FLAGS:   s_d.rdata = flags;
                ADDR_X_HI:    s_d.rdata = msb_v[0];
                ADDR_X_LO:    s_d.rdata = lsb_v[0];
                ADDR_Y_HI:    s_d.rdata = msb_v[1];
                ADDR_Y_LO:    s_d.rdata = lsb_v[1];
                ADDR_Z_HI:    s_d.rdata = msb_v[2];
                ADDR_Z_LO:    s_d.rdata = lsb_v[2];
                ADDR_CTRL:    s_d.rdata = s_q.ctrl;
                ADDR_IRQ_ST:  s_d.rdata = {{(8-IRQ_W){1'b0}}, irq_st};
                ADDR_IRQ_EN:  s_d.rdata = {{(8-IRQ_W){1'b0}}, irq_en};
                default:      s_d.rdata = BYTE_ZERO; // unmapped reads zero
            endcase
        end else if (wr_i) begin
            s_d.ptr = addr_i;                        // a write positions the pointer
        end
        // combined flags clear once all three high bytes are read
        s_d.mask = seen;
        if (&seen) begin
            s_d.any_fresh = 1'b0;
            s_d.any_ovr   = 1'b0;
            s_d.mask      = '0;
        end
        if (|new_v) begin
            s_d.any_fresh = 1'b1;
        end
        if (irq_ev[IRQ_OVR_BIT]) begin
            s_d.any_ovr = 1'b1;
        end
        // entering measuring mode wipes the flags
        if (act_clr) begin
            s_d.any_fresh = 1'b0;
            s_d.any_ovr   = 1'b0;
            s_d.mask      = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q      <= '0;
            s_q.ctrl <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign rdata_o                   = s_q.rdata;
    assign next_addr_o               = s_q.ptr;
    assign sample_ready_irq_source_o = s_q.any_fresh;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // a status read returns the flag byte of that cycle
    chk_flags_read: assert property (
        rd_i && rd_addr == ADDR_FLAGS
        |=> rdata_o == $past(flags))
        else $error("status byte wrong");

    // read data stand for one cycle only, zero otherwise
    chk_rdata_idle: assert property (
        !rd_i
        |=> rdata_o == BYTE_ZERO)
        else $error("read data outside the answer cycle");

    // any accepted sample raises the combined fresh flag
    chk_any_set: assert property (
        |new_v && !act_clr
        |=> s_q.any_fresh)
        else $error("combined fresh not set");

    // combined fresh only falls on a high read or a mode entry
    chk_any_fall: assert property (
        $fell(s_q.any_fresh)
        |-> $past(|msb_rd) || $past(act_clr))
        else $error("combined fresh cleared without high read");

    // last of the three high reads drops the ready source
    chk_any_clear: assert property (
        &(s_q.mask | msb_rd) && !(|new_v)
        |=> !sample_ready_irq_source_o)
        else $error("ready source kept after all high reads");

    // a newly overwritten axis always shows in the combined flag
    chk_ovr_cover: assert property (
        (ovr_v & ~$past(ovr_v)) != '0
        |-> s_q.any_ovr)
        else $error("axis overrun without combined overrun");

    // y and z low bytes carry zeros below the two sample bits
    chk_low_zero: assert property (
        rd_i && (rd_addr == ADDR_Y_LO || rd_addr == ADDR_Z_LO)
        |=> rdata_o[5:0] == LSB_PAD)
        else $error("low byte pad bits not zero");

    // a status read moves the pointer on to the x high byte
    chk_flags_step: assert property (
        rd_i && rd_addr == ADDR_FLAGS
        |=> s_q.ptr == ADDR_X_HI)
        else $error("pointer did not step from status to x high");

    // full burst: a high byte is followed by its low byte
    chk_burst_step: assert property (
        rd_i && burst_i && s_q.ptr == ADDR_X_HI && !s_q.ctrl[CTRL_FAST_BIT]
        |=> s_q.ptr == ADDR_X_LO)
        else $error("burst did not step to low byte");

    // full burst wraps to status after the z low byte
    chk_full_wrap: assert property (
        rd_i && burst_i && s_q.ptr == ADDR_Z_LO
        |=> s_q.ptr == ADDR_FLAGS)
        else $error("full burst did not wrap");

    // fast burst: a high byte is followed by the next high byte
    chk_fast_skip: assert property (
        rd_i && burst_i && s_q.ptr == ADDR_X_HI && s_q.ctrl[CTRL_FAST_BIT]
        |=> s_q.ptr == ADDR_Y_HI)
        else $error("fast read did not skip low byte");

    // fast burst wraps to status after the z high byte
    chk_fast_wrap: assert property (
        rd_i && burst_i && s_q.ptr == ADDR_Z_HI && s_q.ctrl[CTRL_FAST_BIT]
        |=> s_q.ptr == ADDR_FLAGS)
        else $error("fast burst did not wrap");

    // no x axis sample is taken in standby
    chk_standby: assert property (
        !s_q.ctrl[CTRL_ACTIVE_BIT] && !fresh_v[0] && !ctrl_wr
        |=> !fresh_v[0])
        else $error("sample taken in standby");

    // combined fresh stays low in standby
    chk_standby_any: assert property (
        !s_q.ctrl[CTRL_ACTIVE_BIT] && !s_q.any_fresh && !ctrl_wr
        |=> !s_q.any_fresh)
        else $error("combined fresh set in standby");

    // a status read alone keeps the ready source
    chk_src_hold: assert property (
        sample_ready_irq_source_o && rd_i && rd_addr == ADDR_FLAGS && !(&s_q.mask)
        |=> sample_ready_irq_source_o)
        else $error("status read cleared ready source");

    // main scenarios
    cov_full_burst: cover property (rd_i && burst_i && s_q.ptr == ADDR_Z_LO);
    cov_fast_burst: cover property (
        rd_i && burst_i && s_q.ctrl[CTRL_FAST_BIT] && s_q.ptr == ADDR_Z_HI);
    cov_all_read: cover property (s_q.any_fresh ##1 !s_q.any_fresh);
    cov_irq: cover property (irq_o);
endmodule

// ---- shared/asor_pkg.sv ----
// shared constants for the accelerometer sample output register block
package asor_pkg;
    // sample geometry
    localparam int unsigned SMP_W      = 10;     // bits per axis sample
    localparam int unsigned AXES       = 3;      // x, y, z
    localparam logic [5:0]  LSB_PAD    = 6'h00;  // unused low bits of a low byte
    // register offsets
    localparam logic [7:0]  ADDR_FLAGS = 8'h00;  // sample_flags
    localparam logic [7:0]  ADDR_X_HI  = 8'h01;  // x_sample_high
    localparam logic [7:0]  ADDR_X_LO  = 8'h02;  // x_sample_low
    localparam logic [7:0]  ADDR_Y_HI  = 8'h03;  // y_sample_high
    localparam logic [7:0]  ADDR_Y_LO  = 8'h04;  // y_sample_low
    localparam logic [7:0]  ADDR_Z_HI  = 8'h05;  // z_sample_high
    localparam logic [7:0]  ADDR_Z_LO  = 8'h06;  // z_sample_low
    localparam logic [7:0]  ADDR_CTRL  = 8'h2A;  // primary_control
    localparam logic [7:0]  ADDR_IRQ_ST  = 8'h40; // interrupt status, read only
    localparam logic [7:0]  ADDR_IRQ_CLR = 8'h41; // interrupt clear, write only
    localparam logic [7:0]  ADDR_IRQ_EN  = 8'h42; // interrupt enable
    // primary_control fields
    localparam int unsigned CTRL_ACTIVE_BIT = 0;  // measuring mode
    localparam int unsigned CTRL_FAST_BIT   = 1;  // skip low bytes on increment
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    // interrupt status fields
    localparam int unsigned IRQ_W         = 2;
    localparam int unsigned IRQ_READY_BIT = 0;    // new sample on any axis
    localparam int unsigned IRQ_OVR_BIT   = 1;    // a sample was overwritten
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    // misc reset values
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
endpackage

// ---- design/asor_axis.sv ----
// one axis: sample store, fresh and overrun flags, low byte hold
`timescale 1ns/1ns
module asor_axis
    import asor_pkg::*;
#(
    parameter int unsigned W = SMP_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // sample side
    input  wire logic         new_i,      // accepted new sample strobe
    input  wire logic [W-1:0] sample_i,   // two's complement sample
    input  wire logic         clr_i,      // wipe on entry to measuring
    // read side
    input  wire logic         msb_rd_i,   // high byte is being read
    output logic              fresh_o,
    output logic              ovr_o,
    output logic [7:0]        msb_o,
    output logic [7:0]        lsb_o
);
    // all axis state
    typedef struct packed {
        logic          fresh;
        logic          ovr;
        logic [W-1:0]  smp;
        logic [W-9:0]  lsb_hold;
    } asor_axis_s;

    asor_axis_s s_q;   // registered state
    asor_axis_s s_d;   // next state
    logic [W-9:0] smp_lo;  // live low bits, for checks

    // next state: read clears first, a new sample then wins
    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.fresh = 1'b0;
            s_d.ovr   = 1'b0;
        end else begin
            if (msb_rd_i) begin
                s_d.fresh    = 1'b0;
                s_d.ovr      = 1'b0;
                s_d.lsb_hold = s_q.smp[W-9:0];
            end
            if (new_i) begin
                s_d.smp   = sample_i;
                s_d.fresh = 1'b1;
                if (s_q.fresh && !msb_rd_i) begin
                    s_d.ovr = 1'b1;
                end
            end
        end
    end

    // state register, flags clear at reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // byte views of the sample
    assign fresh_o = s_q.fresh;
    assign ovr_o   = s_q.ovr;
    assign msb_o   = s_q.smp[W-1:W-8];
    assign lsb_o   = {s_q.lsb_hold, LSB_PAD};
    assign smp_lo  = s_q.smp[W-9:0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_fresh_set: assert property (new_i && !clr_i |=> fresh_o)
        else $error("fresh flag not set by new sample");
    chk_fresh_clear: assert property (
        msb_rd_i && !new_i && !clr_i |=> !fresh_o && !ovr_o)
        else $error("high byte read did not clear flags");
    chk_ovr_set: assert property (new_i && fresh_o && !msb_rd_i && !clr_i |=> ovr_o)
        else $error("overrun not flagged");
    chk_lsb_pair: assert property (msb_rd_i && !clr_i |=> lsb_o[7:6] == $past(smp_lo))
        else $error("low byte not paired with high byte");
    chk_lsb_stable: assert property (!msb_rd_i |=> $stable(lsb_o))
        else $error("held low byte changed without read");
    cov_overwrite: cover property (fresh_o && new_i && !msb_rd_i);
endmodule

// ---- design/asor_irq.sv ----
// sticky interrupt status with enable and write-one clear
`timescale 1ns/1ns
module asor_irq
    import asor_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // events
    input  wire logic [IRQ_W-1:0] event_i,
    // software side
    input  wire logic             clr_wr_i,
    input  wire logic             en_wr_i,
    input  wire logic [IRQ_W-1:0] wdata_i,
    output logic      [IRQ_W-1:0] status_o,
    output logic      [IRQ_W-1:0] enable_o,
    output logic                  irq_o
);
    // interrupt state
    typedef struct packed {
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] enable;
        logic             irq;
    } asor_irq_s;

    asor_irq_s s_q;  // registered state
    asor_irq_s s_d;  // next state

    // a set in the clear cycle survives
    always_comb begin
        s_d = s_q;
        if (clr_wr_i) begin
            s_d.status = s_q.status & ~wdata_i;
        end
        s_d.status = s_d.status | event_i;
        if (en_wr_i) begin
            s_d.enable = wdata_i;
        end
        s_d.irq = |(s_d.status & s_d.enable);
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_o = s_q.status;
    assign enable_o = s_q.enable;
    assign irq_o    = s_q.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_irq_sticky: assert property (|event_i |=> (status_o & $past(event_i)) == $past(event_i))
        else $error("event lost from status");
endmodule

// ---- bench/asor_host_model.sv ----
// register bus master that stands in for the serial host
`timescale 1ns/1ns
module asor_host_model (
    // clock
    input  wire logic       clk_i,
    // register port toward the block
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            burst_o,
    input  wire logic [7:0] rdata_i
);
    logic [7:0] last_rd;     // last address read without auto-increment
    int         order_faults; // low byte reads not led by their high byte

    // idle bus at time zero
    initial begin
        addr_o       = 8'h00;
        wdata_o      = 8'h00;
        wr_o         = 1'b0;
        rd_o         = 1'b0;
        burst_o      = 1'b0;
        last_rd      = 8'hFF;
        order_faults = 0;
    end

    // one cycle write, lines scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask

    // one cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
        if (!b && (a == 8'h02 || a == 8'h04 || a == 8'h06) && last_rd != a - 8'h01) begin
            order_faults++;
        end
        last_rd = b ? 8'hFF : a;
        @(posedge clk_i);
        addr_o  <= a;
        rd_o    <= 1'b1;
        burst_o <= b;
        @(posedge clk_i);
        rd_o    <= 1'b0;
        burst_o <= 1'b0;
        addr_o  <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule

// ---- bench/asor_top_tb.sv ----
// self-checking bench for the sample output register block
`timescale 1ns/1ns
module asor_top_tb
    import asor_pkg::*;
;
    logic             clk_i   = 1'b0;
    logic             rst_n_i = 1'b0;
    wire logic [7:0]  addr, wdata, rdata, next_addr;
    wire logic        wr, rd, burst, src, irq;
    logic [2:0]       smp_new = 3'h0;    // z, y, x strobes
    logic [SMP_W-1:0] x_smp   = '0;
    logic [SMP_W-1:0] y_smp   = '0;
    logic [SMP_W-1:0] z_smp   = '0;
    logic [7:0]       v;
    int               n_fail = 0;
    int               total_checks = 0;
    int               cyc = 0;

    always #4 clk_i = ~clk_i;

    asor_host_model u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .burst_o(burst), .rdata_i(rdata));

    asor_top #(.W(SMP_W)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .burst_i(burst), .rdata_o(rdata),
        .next_addr_o(next_addr), .x_new_i(smp_new[0]), .x_sample_i(x_smp),
        .y_new_i(smp_new[1]), .y_sample_i(y_smp), .z_new_i(smp_new[2]),
        .z_sample_i(z_smp), .sample_ready_irq_source_o(src), .irq_o(irq));

    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // closing report
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // present samples for one cycle, then scramble the lines
    task automatic push(input logic [2:0] m, input logic [SMP_W-1:0] vx, vy, vz);
        @(posedge clk_i);
        smp_new <= m;
        x_smp   <= vx;
        y_smp   <= vy;
        z_smp   <= vz;
        @(posedge clk_i);
        smp_new <= 3'h0;
        x_smp   <= ~vx;
        y_smp   <= ~vy;
        z_smp   <= ~vz;
    endtask

    // let registered outputs land
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // flags, control and ready source clear after reset
    task automatic t_reset();
        u_host.rd(ADDR_FLAGS, 1'b0, v);
        check("flags", v, 8'h00);
        u_host.rd(ADDR_CTRL, 1'b0, v);
        check("control", v, CTRL_RST);
        check("ready source", {7'h00, src}, 8'h00);
        $display("test reset done");
    endtask

    // overwrite of an unread x sample, then high and low reads
    task automatic t_overrun();
        u_host.wr(ADDR_CTRL, 8'h01);
        push(3'b001, 10'h2B5, 10'h000, 10'h000);
        push(3'b001, 10'h16A, 10'h000, 10'h000);
        u_host.rd(ADDR_FLAGS, 1'b0, v);
        check("flags overrun", v, 8'h99);
        check("ready source set", {7'h00, src}, 8'h01);
        u_host.rd(ADDR_X_HI, 1'b0, v);
        check("x high", v, 8'h5A);
        u_host.rd(ADDR_X_LO, 1'b0, v);
        check("x low", v, 8'h80);
        u_host.rd(ADDR_FLAGS, 1'b0, v);
        check("flags after x", v, 8'h88);
        $display("test overrun done");
    endtask

    // seven byte burst clears combined flags at the last high read
    task automatic t_burst();
        logic [7:0] exp [7] = '{8'h8E, 8'h5A, 8'h80, 8'hFF, 8'hC0, 8'h00, 8'hC0};
        push(3'b110, 10'h000, 10'h3FF, 10'h003);
        for (int i = 0; i < 7; i++) begin
            u_host.rd(ADDR_FLAGS, i != 0, v);
            check("burst byte", v, exp[i]);
        end
        check("pointer wrap", next_addr, 8'h00);
        check("ready source cleared", {7'h00, src}, 8'h00);
        u_host.rd(ADDR_FLAGS, 1'b0, v);
        check("flags all read", v, 8'h00);
        $display("test burst done");
    endtask

    // fast read returns status and high bytes only
    task automatic t_fast();
        logic [7:0] exp [4] = '{8'h0F, 8'hAD, 8'hFF, 8'h00};
        u_host.wr(ADDR_CTRL, 8'h03);
        push(3'b111, 10'h2B5, 10'h3FF, 10'h003);
        for (int i = 0; i < 4; i++) begin
            u_host.rd(ADDR_FLAGS, i != 0, v);
            check("fast byte", v, exp[i]);
        end
        check("fast pointer wrap", next_addr, 8'h00);
        u_host.rd(ADDR_FLAGS, 1'b0, v);
        check("flags after fast", v, 8'h00);
        $display("test fast done");
    endtask

    // new sample between high and low read keeps the pair coherent
    task automatic t_coherent();
        u_host.wr(ADDR_CTRL, 8'h01);
        push(3'b001, 10'h2B5, 10'h000, 10'h000);
        u_host.rd(ADDR_X_HI, 1'b0, v);
        check("x high first", v, 8'hAD);
        push(3'b001, 10'h16A, 10'h000, 10'h000);
        u_host.rd(ADDR_X_LO, 1'b0, v);
        check("x low held", v, 8'h40);
        u_host.rd(ADDR_X_HI, 1'b0, v);
        check("x high new", v, 8'h5A);
        $display("test coherent done");
    endtask

    // interrupt raise, mask, clear; standby and refused accesses
    task automatic t_irq();
        u_host.wr(ADDR_IRQ_CLR, 8'h03);
        u_host.rd(ADDR_IRQ_ST, 1'b0, v);
        check("irq status cleared", v, 8'h00);
        u_host.wr(ADDR_IRQ_EN, 8'h01);
        push(3'b001, 10'h2B5, 10'h000, 10'h000);
        settle();
        check("irq raised", {7'h00, irq}, 8'h01);
        u_host.rd(ADDR_IRQ_ST, 1'b0, v);
        check("irq status", v, 8'h01);
        u_host.wr(ADDR_IRQ_EN, 8'h00);
        settle();
        check("irq masked", {7'h00, irq}, 8'h00);
        u_host.wr(ADDR_IRQ_EN, 8'h01);
        settle();
        check("irq unmasked", {7'h00, irq}, 8'h01);
        u_host.wr(ADDR_IRQ_CLR, 8'h01);
        settle();
        check("irq cleared", {7'h00, irq}, 8'h00);
        u_host.wr(ADDR_CTRL, 8'h00);
        push(3'b001, 10'h16A, 10'h000, 10'h000);
        u_host.wr(ADDR_X_HI, 8'h55);
        u_host.rd(ADDR_FLAGS, 1'b0, v);
        check("flags in standby", v, 8'h09);
        u_host.rd(ADDR_X_HI, 1'b0, v);
        check("x high kept", v, 8'hAD);
        u_host.rd(8'h10, 1'b0, v);
        check("unmapped", v, 8'h00);
        check("host order", u_host.order_faults[7:0], 8'h00);
        $display("test irq done");
    endtask

    // cut a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_overrun();
        t_burst();
        t_fast();
        t_coherent();
        t_irq();
        results();
    end
endmodule
